// file: verilog/dcu_pkg.sv
// What this block does
// - opcode 0111 decodes track offset modifiers
// - no offset hardware: offset command is no-op
// - unsupported offset magnitudes still accepted
// - seek or recalibrate clears all offsets
// - diagnostics end with complete, fault adds attention
// - diag parameter zero standard, unimplemented rejected unless DIAG_ALTS is 0
// - parameter byte zero always runs correctly
// - opcode 1001 loads low bytes-per-sector, hard only
// - drive may adjust requested bytes per sector
// - controller reads back sector configuration afterward; dcu_ctrl issues no such read
// - opcode 1010 captures high four value bits
// - high bytes-per-sector sent before low command
// - high value: complete, attention if invalid
// - seek high bits combine with next seek
// - distance/direction high bits precede changed seek
// - opcode 1011 formats one optical track
// - opcode 1110 switch number and parameter
// - switch 1100 sets spindle master or slave
// - switch 1101 selects zone, reject past last
// - zone 0 acts as single-frequency drive
// - soft switch 0 overrides physical switch positions
// - opcodes 1111, 1100, 1101 reserved
package dcu_pkg;
	localparam int OP_MSB = 15;
	localparam int MOD_MSB = 11;
	localparam int MOD_LSB = 8;
	localparam int PAR_MSB = 7;
	localparam logic [3:0] OP_SEEK = 4'h0;
	localparam logic [3:0] OP_RECAL = 4'h1;
	localparam logic [3:0] OP_TRK_OFS = 4'h7;
	localparam logic [3:0] OP_DIAG = 4'h8;
	localparam logic [3:0] OP_SET_BPS = 4'h9;
	localparam logic [3:0] OP_HIGH_VAL = 4'hA;
	localparam logic [3:0] OP_FORMAT = 4'hB;
	localparam logic [3:0] OP_RSV_C = 4'hC;
	localparam logic [3:0] OP_RSV_D = 4'hD;
	localparam logic [3:0] OP_SET_CFG = 4'hE;
	localparam logic [3:0] OP_LINK = 4'hF;
	localparam logic [3:0] HV_ABS = 4'h0;
	localparam logic [3:0] HV_DIR_MIN = 4'h1;
	localparam logic [3:0] HV_DIR_MAX = 4'h2;
	localparam logic [3:0] HV_BPS = 4'h3;
	localparam logic [3:0] SW_SYNC = 4'hC;
	localparam logic [3:0] SW_ZONE = 4'hD;
	localparam logic [7:0] SYNC_SLAVE = 8'h00;
	localparam logic [7:0] SYNC_MASTER = 8'h01;
	localparam logic [7:0] PAR_ZERO = 8'h00;
	localparam logic [7:0] DIAG_FIRST_ALT = 8'h01;
	localparam logic [3:0] ZONE_SINGLE = 4'h0;
	localparam logic [15:0] BPS_RESET = 16'h0000;
	localparam logic [1:0] A_CMD = 2'h0;
	localparam logic [1:0] A_STAT = 2'h1;
	localparam logic [1:0] A_LAST = 2'h2;
endpackage

// file: verilog/dcu_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// command word one way, completion and attention back
interface dcu_link_if;
	logic cmd_valid;
	logic [15:0] cmd_word;
	logic cmd_complete;
	logic attention;
	modport drive (input cmd_valid, input cmd_word, output cmd_complete, output attention);
	modport ctrl (output cmd_valid, output cmd_word, input cmd_complete, input attention);
endinterface
`default_nettype wire

// file: verilog/dcu_diag_engine.sv
`timescale 1ns/1ns
`default_nettype none
// runs a diagnostic routine for RUN_CYCLES cycles, fewer when param[1:0] is nonzero
module dcu_diag_engine import dcu_pkg::*; #(
	parameter int RUN_CYCLES = 64
) (
	input wire logic clock, // system clock
	input wire logic reset_n, // sync reset
	input wire logic start, // one-cycle start
	input wire logic [7:0] param, // vendor parameter byte
	input wire logic fault_in, // self-test fault sense
	output logic done, // one-cycle finish
	output logic fault // fault seen, valid with done
);
	// refuse run lengths the 16-bit counter cannot hold
	if (RUN_CYCLES < 2 || RUN_CYCLES > 65535) begin : g_bad_run
		$error("RUN_CYCLES out of range");
	end
	logic [15:0] cnt_q;
	logic busy_q;
	logic fault_q;
	logic done_q;
	wire last = busy_q && (cnt_q == 16'h0000);
	// parameter only shortens the run; zero runs the full routine
	wire [15:0] load = 16'(RUN_CYCLES - 1) >> param[1:0];
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			fault_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= last;
			if (start) begin
				busy_q <= 1'b1;
				cnt_q <= load;
				fault_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 16'h0001;
				fault_q <= fault_q | fault_in;
				if (last) busy_q <= 1'b0;
			end
		end
	end
	assign done = done_q;
	assign fault = fault_q;
endmodule
`default_nettype wire

// file: verilog/dcu_drive.sv
`timescale 1ns/1ns
`default_nettype none
// drive-side decoder for upper opcodes plus seek/recalibrate
module dcu_drive import dcu_pkg::*; #(
	parameter bit HAS_TRK_OFS = 1'b1,
	parameter int OFS_LEVELS = 2,
	parameter int DIAG_ALTS = 2,
	parameter int NUM_ZONES = 4,
	parameter bit HAS_DD_SEEK = 1'b1,
	parameter bit HAS_FORMAT = 1'b1,
	parameter int FORMAT_CYCLES = 200,
	parameter logic [15:0] MAX_TRACK = 16'h0FFF,
	parameter logic [15:0] BPS_MIN = 16'h0100,
	parameter logic [15:0] BPS_MAX = 16'h7FFF
) (
	input wire logic clock, // 20 MHz clock
	input wire logic reset_n, // sync reset
	dcu_link_if.drive link, // command link
	input wire logic hard_sector, // configured hard sectored
	input wire logic [7:0] phys_switch, // physical switch bank
	input wire logic diag_fault_in, // self-test fault sense
	output logic [2:0] trk_ofs_mag, // track offset amount
	output logic trk_ofs_neg, // offset direction negative
	output logic [15:0] bps_q_out, // bytes per sector applied
	output logic [15:0] seek_target, // last seek target
	output logic seek_toward_max, // last seek direction
	output logic spindle_master, // spindle sync master
	output logic [3:0] zone, // selected zone, 0 single-frequency
	output logic [7:0] eff_switch // effective switch settings
);
	// refuse parameter values the decode cannot serve
	if (OFS_LEVELS < 0 || OFS_LEVELS > 3) begin : g_bad_ofs
		$error("OFS_LEVELS out of range");
	end
	if (NUM_ZONES < 1 || NUM_ZONES > 15) begin : g_bad_zones
		$error("NUM_ZONES out of range");
	end
	if (DIAG_ALTS < 0 || DIAG_ALTS > 15) begin : g_bad_alts
		$error("DIAG_ALTS out of range");
	end
	if (FORMAT_CYCLES < 1 || FORMAT_CYCLES > 65535) begin : g_bad_fmt
		$error("FORMAT_CYCLES out of range");
	end
	typedef enum logic [1:0] {ST_IDLE, ST_DIAG, ST_FMT, ST_DONE} dcu_state_e;
	dcu_state_e state_q;
	logic cc_q, att_q, att_d;
	logic cmd_seen_q;
	logic [15:0] fmt_cnt_q;
	logic [2:0] mag_q;
	logic neg_q;
	logic [15:0] bps_q;
	logic [3:0] hi_seek_q, hi_bps_q;
	logic dir_max_q;
	logic [15:0] seek_q;
	logic master_q;
	logic [3:0] zone_q;
	logic [15:0] sw_mask_q;
	logic [7:0] sw_val_q [16];
	logic diag_done, diag_fault;
	logic [9:0] pin_s1_q;
	logic [9:0] pin_s2_q;
	// pins pass two flops so no decode sees a metastable level
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pin_s1_q <= 10'h000;
			pin_s2_q <= 10'h000;
		end else begin
			pin_s1_q <= {hard_sector, diag_fault_in, phys_switch};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire hard_sync = pin_s2_q[9];
	wire fault_sync = pin_s2_q[8];
	wire [7:0] phys_sync = pin_s2_q[7:0];
	// command field decode
	wire take = link.cmd_valid && !cmd_seen_q && state_q == ST_IDLE;
	wire [3:0] op = link.cmd_word[OP_MSB -: 4];
	wire [3:0] md = link.cmd_word[MOD_MSB:MOD_LSB];
	wire [7:0] pr = link.cmd_word[PAR_MSB:0];
	wire [11:0] low12 = link.cmd_word[11:0];
	wire [15:0] bps_new = {hi_bps_q, low12};
	wire [15:0] seek_new = {hi_seek_q, low12};
	wire [1:0] ofs_req = md[2:1];
	wire ofs_rsv = md[3];
	wire [2:0] ofs_cap = (32'(ofs_req) > OFS_LEVELS) ? 3'(OFS_LEVELS) : {1'b0, ofs_req};
	wire diag_ok = (pr == PAR_ZERO) ? 1'b1 : (DIAG_ALTS == 0) ? 1'b1 : 32'(pr) <= DIAG_ALTS;
	wire bps_ok = hard_sync && bps_new >= BPS_MIN && bps_new <= BPS_MAX;
	wire hv_rsv = md > HV_BPS || (!HAS_DD_SEEK && (md == HV_DIR_MIN || md == HV_DIR_MAX));
	wire hv_val_ok = (md == HV_BPS) ? hard_sync : ({pr[3:0], 12'h000} <= MAX_TRACK);
	wire sw_ok = (md == SW_SYNC) ? (pr == SYNC_SLAVE || pr == SYNC_MASTER) :
		(md == SW_ZONE) ? (32'(pr) <= NUM_ZONES) :
		!md[3]; // vendor switches 0000-0111
	wire op_rsv = op == OP_RSV_C || op == OP_RSV_D || op == OP_LINK || (op == OP_FORMAT && !HAS_FORMAT);
	// attention for the immediate answer of each command
	always_comb begin
		att_d = 1'b0;
		unique case (op)
			OP_TRK_OFS: att_d = ofs_rsv;
			OP_SET_BPS: att_d = !bps_ok;
			OP_HIGH_VAL: att_d = hv_rsv || !hv_val_ok;
			OP_SET_CFG: att_d = !sw_ok;
			OP_SEEK: att_d = seek_new > MAX_TRACK;
			default: att_d = op_rsv;
		endcase
	end
	dcu_diag_engine u_diag (
		.clock(clock),
		.reset_n(reset_n),
		.start(take && op == OP_DIAG && diag_ok),
		.param(pr),
		.fault_in(fault_sync),
		.done(diag_done),
		.fault(diag_fault)
	);
	// sequencer: answer, long runs, hold complete until word drops
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			cc_q <= 1'b0;
			att_q <= 1'b0;
			cmd_seen_q <= 1'b0;
			fmt_cnt_q <= 16'h0000;
		end else begin
			if (!link.cmd_valid) cmd_seen_q <= 1'b0;
			// attention only ever stands beside complete
			if (!link.cmd_valid) begin
				cc_q <= 1'b0;
				att_q <= 1'b0;
			end
			unique case (state_q)
				ST_IDLE: if (take) begin
					cmd_seen_q <= 1'b1;
					if (op == OP_DIAG && diag_ok) begin
						state_q <= ST_DIAG;
					end else if (op == OP_FORMAT && HAS_FORMAT) begin
						state_q <= ST_FMT;
						fmt_cnt_q <= 16'(FORMAT_CYCLES);
					end else begin
						cc_q <= 1'b1;
						att_q <= (op == OP_DIAG) ? 1'b1 : att_d;
					end
				end
				ST_DIAG: if (diag_done) begin
					cc_q <= 1'b1;
					att_q <= diag_fault;
					state_q <= ST_IDLE;
				end
				ST_FMT: begin
					fmt_cnt_q <= fmt_cnt_q - 16'h0001;
					if (fmt_cnt_q == 16'h0001) state_q <= ST_DONE;
				end
				ST_DONE: begin
					cc_q <= 1'b1;
					att_q <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
	// offset, size, seek state
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mag_q <= 3'b000;
			neg_q <= 1'b0;
			bps_q <= BPS_RESET;
			hi_bps_q <= 4'h0;
			hi_seek_q <= 4'h0;
			dir_max_q <= 1'b0;
			seek_q <= 16'h0000;
		end else if (take && !att_d) begin
			if (op == OP_SEEK || op == OP_RECAL) begin
				mag_q <= 3'b000;
				neg_q <= 1'b0;
				seek_q <= (op == OP_RECAL) ? 16'h0000 : seek_new;
			end
			if (op == OP_TRK_OFS && HAS_TRK_OFS) begin
				mag_q <= md[3:1] == 3'b000 ? 3'b000 : ofs_cap;
				neg_q <= md[0] && md[3:1] != 3'b000;
			end
			if (op == OP_SET_BPS) bps_q <= bps_new;
			if (op == OP_HIGH_VAL) begin
				if (md == HV_BPS) hi_bps_q <= pr[3:0];
				if (md == HV_ABS) hi_seek_q <= pr[3:0];
				if (md == HV_DIR_MIN || md == HV_DIR_MAX) begin
					hi_seek_q <= pr[3:0];
					dir_max_q <= md == HV_DIR_MAX;
				end
			end
		end
	end
	// soft switch store
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			master_q <= 1'b0;
			zone_q <= ZONE_SINGLE;
			sw_mask_q <= 16'h0000;
		end else if (take && op == OP_SET_CFG && sw_ok) begin
			if (md == SW_SYNC) master_q <= pr == SYNC_MASTER;
			if (md == SW_ZONE) zone_q <= pr[3:0];
			sw_mask_q[md] <= 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (take && op == OP_SET_CFG && sw_ok) sw_val_q[md] <= pr;
	end
	// soft value of switch 0 overrides the physical bank once written
	assign eff_switch = sw_mask_q[0] ? sw_val_q[0] : phys_sync;
	assign link.cmd_complete = cc_q;
	assign link.attention = att_q;
	assign trk_ofs_mag = mag_q;
	assign trk_ofs_neg = neg_q;
	assign bps_q_out = bps_q;
	assign seek_target = seek_q;
	assign seek_toward_max = dir_max_q;
	assign spindle_master = master_q;
	assign zone = zone_q;
endmodule
`default_nettype wire

// file: verilog/dcu_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// controller end: software port issues words, status reports results
module dcu_ctrl import dcu_pkg::*; (
	input wire logic clock, // 20 MHz clock
	input wire logic reset_n, // sync reset
	dcu_link_if.ctrl link, // command link
	input wire logic [1:0] addr, // register address
	input wire logic [15:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [15:0] rdata // read data, cycle after rd
);
	logic valid_q, busy_q, att_q, done_q;
	logic [15:0] word_q, last_q, rdata_q;
	// both ends share one clock, so the answer lines are read directly
	wire cc_in = link.cmd_complete;
	wire at_in = link.attention;
	wire issue = wr && addr == A_CMD && !busy_q; // order is software's
	// drop valid on complete, wait complete low before next word
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			valid_q <= 1'b0;
			busy_q <= 1'b0;
			att_q <= 1'b0;
			done_q <= 1'b0;
			word_q <= 16'h0000;
			last_q <= 16'h0000;
		end else begin
			if (issue) begin
				valid_q <= 1'b1;
				busy_q <= 1'b1;
				done_q <= 1'b0;
				word_q <= wdata;
			end else if (valid_q && cc_in) begin
				valid_q <= 1'b0;
				att_q <= at_in; // software reads results
				last_q <= word_q;
			end else if (busy_q && !valid_q && !cc_in) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
		end
	end
	wire [15:0] rd_mux = (addr == A_STAT) ? {13'h0000, att_q, done_q, busy_q} :
		(addr == A_LAST) ? last_q : (addr == A_CMD) ? word_q : 16'h0000;
	always_ff @(posedge clock) begin
		if (!reset_n) rdata_q <= 16'h0000;
		else rdata_q <= rd ? rd_mux : 16'h0000;
	end
	assign rdata = rdata_q;
	assign link.cmd_valid = valid_q;
	assign link.cmd_word = word_q;
endmodule
`default_nettype wire

// file: verification/dcu_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// watches the command link between the two ends
module dcu_link_assertions #(
	parameter int NUM_ZONES = 4
) (
	input wire logic clock, // system clock
	input wire logic reset_n, // sync reset
	input wire logic cmd_valid, // command held by controller
	input wire logic [15:0] cmd_word, // command word
	input wire logic cmd_complete, // drive finished
	input wire logic attention // drive reject or fault
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// fields of the word being answered
	wire logic [3:0] op = cmd_word[15:12];
	wire logic [3:0] md = cmd_word[11:8];
	wire logic [7:0] pr = cmd_word[7:0];
	// handshake shape
	chk_att_with_cc: assert property (attention |-> cmd_complete)
		else $error("attention without complete");
	chk_cc_has_req: assert property ($rose(cmd_complete) |-> $past(cmd_valid))
		else $error("complete without request");
	chk_cc_release: assert property ($fell(cmd_valid) |=> !cmd_complete)
		else $error("complete held after release");
	chk_offset_fast: assert property ($rose(cmd_valid) && op == 4'h7 |-> ##[1:4] cmd_complete)
		else $error("offset not answered");
	// reject decisions
	chk_offset_rsv: assert property ($rose(cmd_complete) && op == 4'h7 |-> attention == md[3])
		else $error("offset reject wrong");
	chk_resv_opcode: assert property ($rose(cmd_complete) && op inside {4'hC, 4'hD, 4'hF}
		|-> attention)
		else $error("reserved opcode accepted");
	chk_high_rsv: assert property ($rose(cmd_complete) && op == 4'hA && md > 4'h3 |-> attention)
		else $error("high value modifier accepted");
	chk_sync_param: assert property ($rose(cmd_complete) && op == 4'hE && md == 4'hC
		|-> attention == (pr > 8'h01))
		else $error("sync parameter decision wrong");
	chk_zone_range: assert property ($rose(cmd_complete) && op == 4'hE && md == 4'hD
		|-> attention == (pr > NUM_ZONES))
		else $error("zone decision wrong");
	chk_switch_rsv: assert property ($rose(cmd_complete) && op == 4'hE
		&& md inside {[4'h8:4'hB], 4'hE, 4'hF} |-> attention)
		else $error("reserved switch accepted");
endmodule
`default_nettype wire

// file: verification/test_disk_drive_command_decoder_upper.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", n, e, a); end end
// both ends joined, software port driven, drive state observed
module test_disk_drive_command_decoder_upper;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hard_sector = 1'b0;
	logic diag_fault_in = 1'b0;
	logic [7:0] phys_switch = 8'h3C;
	logic [1:0] addr = 2'd0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata, bps, tgt, rv;
	logic [2:0] mag;
	logic neg, dirx, sm;
	logic [3:0] zone;
	logic [7:0] effs;
	logic [3:0] rsv [3] = '{4'hC, 4'hD, 4'hF};
	int miscompares = 0;
	int compares = 0;
	dcu_link_if link();
	dcu_drive i_dcu_drive (.clock(clock), .reset_n(reset_n), .link(link),
		.hard_sector(hard_sector), .phys_switch(phys_switch), .diag_fault_in(diag_fault_in),
		.trk_ofs_mag(mag), .trk_ofs_neg(neg), .bps_q_out(bps), .seek_target(tgt),
		.seek_toward_max(dirx), .spindle_master(sm), .zone(zone), .eff_switch(effs));
	dcu_ctrl i_dcu_ctrl (.clock(clock), .reset_n(reset_n), .link(link), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	dcu_link_assertions #(.NUM_ZONES(4)) i_dcu_link_assertions (.clock(clock),
		.reset_n(reset_n), .cmd_valid(link.cmd_valid), .cmd_word(link.cmd_word),
		.cmd_complete(link.cmd_complete), .attention(link.attention));
	// 50 ns clock
	always #25 clock = ~clock;
	// one write cycle on the software port
	task wreg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// one read cycle, data taken the cycle after the strobe
	task rreg(input logic [1:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	// issue a command word, poll until done and not busy, check attention
	task cmd(input logic [15:0] w, input logic a);
		int n;
		n = 0;
		wreg(2'd0, w);
		repeat (2) @(posedge clock);
		rreg(2'd1);
		while (rv[1:0] !== 2'b10 && n < 400) begin
			rreg(2'd1);
			n++;
		end
		`CHK("done", 1'b1, rv[1])
		`CHK("attention", a, rv[2])
	endtask
	task print_verdict;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog far beyond the expected thousand or so cycles
	initial begin
		#(20000 * 50);
		miscompares++;
		print_verdict;
	end
	// main sequence
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		`CHK("bps", 16'h0000, bps)
		for (int m = 2; m < 8; m++) begin
			cmd({4'h7, m[3:0], 8'h00}, 1'b0);
			`CHK("mag", (m / 2 > 2) ? 3'd2 : 3'(m / 2), mag)
			`CHK("neg", m[0], neg)
		end
		cmd(16'h7800, 1'b1);
		`CHK("mag", 3'd2, mag)
		cmd(16'h7100, 1'b0);
		`CHK("mag", 3'd0, mag)
		cmd(16'h7300, 1'b0);
		cmd(16'h0005, 1'b0);
		`CHK("mag", 3'd0, mag)
		`CHK("seek", 16'h0005, tgt)
		cmd(16'h7400, 1'b0);
		cmd(16'h1000, 1'b0);
		`CHK("mag", 3'd0, mag)
		`CHK("seek", 16'h0000, tgt)
		cmd(16'hA200, 1'b0);
		cmd(16'h0010, 1'b0);
		`CHK("dir", 1'b1, dirx)
		cmd(16'hA100, 1'b0);
		cmd(16'h0008, 1'b0);
		`CHK("dir", 1'b0, dirx)
		cmd(16'hA400, 1'b1);
		cmd(16'hA001, 1'b1);
		cmd(16'hA000, 1'b0);
		cmd(16'h0FFF, 1'b0);
		`CHK("seek", 16'h0FFF, tgt)
		cmd(16'h9200, 1'b1);
		@(posedge clock) hard_sector <= 1'b1;
		cmd(16'hA301, 1'b0);
		cmd(16'h9200, 1'b0);
		`CHK("bps", 16'h1200, bps)
		cmd(16'hA300, 1'b0);
		cmd(16'h9050, 1'b1);
		`CHK("bps", 16'h1200, bps)
		rreg(2'd2);
		`CHK("last", 16'h9050, rv)
		cmd(16'h8000, 1'b0);
		@(posedge clock) diag_fault_in <= 1'b1;
		cmd(16'h8000, 1'b1);
		@(posedge clock) diag_fault_in <= 1'b0;
		cmd(16'h8001, 1'b0);
		cmd(16'h8003, 1'b1);
		cmd(16'hB000, 1'b0);
		foreach (rsv[i]) cmd({rsv[i], 12'h000}, 1'b1);
		cmd(16'hEC01, 1'b0);
		`CHK("master", 1'b1, sm)
		cmd(16'hEC02, 1'b1);
		`CHK("master", 1'b1, sm)
		cmd(16'hEC00, 1'b0);
		`CHK("master", 1'b0, sm)
		for (int z = 1; z < 6; z++) cmd({8'hED, 8'(z)}, z == 5);
		`CHK("zone", 4'h4, zone)
		cmd(16'hED00, 1'b0);
		`CHK("zone", 4'h0, zone)
		cmd(16'hE900, 1'b1);
		cmd(16'hEF00, 1'b1);
		`CHK("switch", 8'h3C, effs)
		cmd(16'hE0A5, 1'b0);
		`CHK("switch", 8'hA5, effs)
		print_verdict;
	end
endmodule
`default_nettype wire
